/* File: bench/enhanced_pwm_output_unit_test.sv */
// self-checking bench of the pwm unit
// assumes: epou_top, epou_load and the bound checker compiled before
`include "epou_map.svh"
`timescale 1ns/10ps
`default_nettype none

module enhanced_pwm_output_unit_test;
   localparam int LIM = 2000;
   localparam logic [15:0] RST_TAB [6] = '{
      {`EPOU_OFS_CONTROL, `EPOU_RST_CONTROL}, {`EPOU_OFS_DUTY_HIGH, `EPOU_RST_DUTY},
      {`EPOU_OFS_PERIOD_LIMIT, `EPOU_RST_PERIOD_LIMIT},
      {`EPOU_OFS_TIMER_CONTROL, `EPOU_RST_TIMER_CONTROL},
      {`EPOU_OFS_PIN_DIRECTION, 4'h0, `EPOU_RST_PIN_DIRECTION},
      {`EPOU_OFS_STEERING, 4'h0, `EPOU_RST_STEERING}};
   // control, owned pins, always-high pins, ever-high pins
   localparam logic [19:0] MODE_TAB [6] = '{{8'h2C, 4'h1, 4'h0, 4'h1},
      {8'hAC, 4'h3, 4'h0, 4'h3}, {8'h6C, 4'hF, 4'h1, 4'h9},
      {8'hEC, 4'hF, 4'h4, 4'h6}, {8'h6E, 4'hF, 4'h4, 4'hC},
      {8'hED, 4'hF, 4'hC, 4'hE}};
   logic aclk, aresetn, sleep, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, last_resp;
   logic [3:0] pin_o, pin_oe, owns, lvl;
   int fails, check_count;

   epou_top epou_top_inst (.aclk(aclk), .aresetn(aresetn), .sleep(sleep),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .bridge_out_o(pin_o), .bridge_out_oe(pin_oe),
      .unit_owns_pin(owns));
   epou_load epou_load_inst (.drive_level(pin_o), .drive_enable(pin_oe), .pin_level(lvl));

   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   // ==========================================================================
   // shared tasks
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic guard(input int n);
      if (n >= LIM) begin
         fails++;
         $display("[ERR] wait expected done seen timeout");
         summarize();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < LIM);
      last_resp = bresp;
      bready <= 1'b0;
      guard(n);
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < LIM);
      d = rdata;
      last_resp = rresp;
      rready <= 1'b0;
      guard(n);
      @(posedge aclk);
   endtask

   task automatic scan(input int n, output logic [3:0] an, output logic [3:0] orr);
      an = 4'hF;
      orr = 4'h0;
      repeat (n) begin
         @(posedge aclk);
         an &= lvl;
         orr |= lvl;
      end
   endtask

   task automatic meas(output int hi, output int per);
      int n;
      n = 0;
      while (lvl[0] !== 1'b0 && n < LIM) begin @(posedge aclk); n++; end
      while (lvl[0] !== 1'b1 && n < LIM) begin @(posedge aclk); n++; end
      hi = 0;
      while (lvl[0] === 1'b1 && n < LIM) begin @(posedge aclk); hi++; n++; end
      per = hi;
      while (lvl[0] === 1'b0 && n < LIM) begin @(posedge aclk); per++; n++; end
      guard(n);
   endtask

   // ==========================================================================
   // scenarios
   task automatic t_reset();
      logic [31:0] d;
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      chk("oe", pin_oe, 4'h0);
      chk("owns", owns, 4'h0);
      for (int i = 0; i < 6; i++) begin
         rd(RST_TAB[i][15:8], d);
         chk("reset_value", d, {24'h0, RST_TAB[i][7:0]});
      end
      rd(8'h40, d);
      chk("unmapped_rd", d, 32'h0);
      chk("unmapped_rresp", {30'h0, last_resp}, {30'h0, `EPOU_RESP_SLVERR});
      wr(8'h40, 8'hFF);
      chk("unmapped_wr", last_resp, `EPOU_RESP_SLVERR);
   endtask

   task automatic start();
      logic [31:0] d;
      int n;
      wr(`EPOU_OFS_PIN_DIRECTION, 8'h0F);
      wr(`EPOU_OFS_PERIOD_LIMIT, 8'h03);
      wr(`EPOU_OFS_CONTROL, 8'h2C);
      wr(`EPOU_OFS_DUTY_HIGH, 8'h01);
      wr(`EPOU_OFS_FLAGS, 8'h01);
      wr(`EPOU_OFS_TIMER_CONTROL, 8'h04);
      n = 0;
      d = 32'h0;
      while (d[0] !== 1'b1 && n < LIM) begin
         rd(`EPOU_OFS_FLAGS, d);
         n++;
      end
      guard(n);
      wr(`EPOU_OFS_PIN_DIRECTION, 8'h00);
   endtask

   task automatic t_period();
      int hi, per;
      for (int ps = 2; ps >= 0; ps--) begin
         wr(`EPOU_OFS_TIMER_CONTROL, 8'h7C | 8'(ps));
         meas(hi, per);
         meas(hi, per);
         chk("period", per, 16 << (2 * ps));
         chk("high_time", hi, 6 << (2 * ps));
      end
   endtask

   task automatic t_buffer();
      logic [31:0] d;
      int hi, per;
      rd(`EPOU_OFS_DUTY_ACTIVE, d);
      chk("duty_active", d, 32'h1);
      wr(`EPOU_OFS_DUTY_ACTIVE, 8'h55);
      rd(`EPOU_OFS_DUTY_ACTIVE, d);
      chk("duty_active_ro", d, 32'h1);
      wr(`EPOU_OFS_DUTY_HIGH, 8'h02);
      meas(hi, per);
      meas(hi, per);
      chk("new_duty", hi, 10);
   endtask

   task automatic t_limits();
      logic [3:0] an, orr;
      wr(`EPOU_OFS_DUTY_HIGH, 8'h05);
      repeat (40) @(posedge aclk);
      scan(40, an, orr);
      chk("overlong_pulse", an[0], 1'b1);
      wr(`EPOU_OFS_CONTROL, 8'h0C);
      wr(`EPOU_OFS_DUTY_HIGH, 8'h00);
      repeat (40) @(posedge aclk);
      scan(40, an, orr);
      chk("zero_duty", orr[0], 1'b0);
      wr(`EPOU_OFS_CONTROL, 8'h2C);
      wr(`EPOU_OFS_DUTY_HIGH, 8'h01);
   endtask

   task automatic t_sleep();
      logic [31:0] c1, c2, c3;
      sleep <= 1'b1;
      rd(`EPOU_OFS_PERIOD_COUNTER, c1);
      repeat (20) @(posedge aclk);
      rd(`EPOU_OFS_PERIOD_COUNTER, c2);
      chk("frozen_counter", c2, c1);
      sleep <= 1'b0;
      repeat (6) @(posedge aclk);
      rd(`EPOU_OFS_PERIOD_COUNTER, c3);
      chk("resumed_counter", c3 != c1, 1'b1);
   endtask

   task automatic t_modes();
      logic [3:0] an, orr;
      int hi, per;
      for (int i = 0; i < 6; i++) begin
         wr(`EPOU_OFS_CONTROL, MODE_TAB[i][19:12]);
         repeat (40) @(posedge aclk);
         scan(32, an, orr);
         chk("owns", owns, MODE_TAB[i][11:8]);
         chk("always_high", an, MODE_TAB[i][7:4]);
         chk("ever_high", orr, MODE_TAB[i][3:0]);
      end
      // one instruction cycle of dead band on a
      wr(`EPOU_OFS_DEADBAND, 8'h01);
      wr(`EPOU_OFS_CONTROL, 8'hAC);
      meas(hi, per);
      meas(hi, per);
      chk("dead_band_high", hi, 2);
      chk("dead_band_period", per, 16);
      wr(`EPOU_OFS_DEADBAND, 8'h00);
      wr(`EPOU_OFS_STEERING, 8'h05);
      wr(`EPOU_OFS_CONTROL, 8'h2C);
      repeat (4) @(posedge aclk);
      chk("steered_owns", owns, 4'h5);
      wr(`EPOU_OFS_STEERING, 8'h01);
      wr(`EPOU_OFS_CONTROL, 8'h00);
      repeat (4) @(posedge aclk);
      chk("released", {owns, pin_oe}, 8'h00);
      wr(`EPOU_OFS_CONTROL, 8'h2C);
      repeat (40) @(posedge aclk);
   endtask

   initial begin
      fails = 0;
      check_count = 0;
      aresetn = 1'b0;
      sleep = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      @(posedge aclk);
      t_reset();
      start();
      t_period();
      t_buffer();
      t_limits();
      t_sleep();
      t_modes();
      t_reset();
      summarize();
   end
endmodule
`default_nettype wire

/* File: bench/epou_load.sv */
// load on the four bridge pins
// assumes: pins pulled low by the load when no one drives them
`timescale 1ns/10ps
`default_nettype none

module epou_load (
   input wire logic [3:0] drive_level,
   input wire logic [3:0] drive_enable,
   output logic [3:0] pin_level
);
   // released pins settle low through the pull-downs
   assign pin_level = drive_level & drive_enable;
endmodule
`default_nettype wire

/* File: bench/epou_monitor.sv */
// checker of the pwm unit's port behaviour
// assumes: bound to epou_top, one clock, synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none

module epou_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sleep,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [3:0] bridge_out_o,
   input wire logic [3:0] bridge_out_oe,
   input wire logic [3:0] unit_owns_pin
);
   // ==========================================================================
   // assertions
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_rst_pins;
      $rose(aresetn) |-> bridge_out_oe == 4'h0 && unit_owns_pin == 4'h0;
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins not inputs after reset");

   property p_oe_owned;
      (bridge_out_oe & ~unit_owns_pin) == 4'h0;
   endproperty
   a_oe_owned: assert property (p_oe_owned)
      else $error("pin driven while not owned");

   property p_out_owned;
      (bridge_out_o & ~unit_owns_pin) == 4'h0;
   endproperty
   a_out_owned: assert property (p_out_owned)
      else $error("level on a pin that is not owned");

   property p_sleep_freeze;
      sleep |=> $stable(bridge_out_o) && $stable(bridge_out_oe);
   endproperty
   a_sleep_freeze: assert property (p_sleep_freeze)
      else $error("pins moved during sleep");

   property p_w_resp;
      $rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_w_resp: assert property (p_w_resp)
      else $error("write answered before address and data taken");

   property p_w_done;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
   endproperty
   a_w_done: assert property (p_w_done)
      else $error("write response not retired");

   property p_r_cause;
      $rose(s_axi_rvalid) |-> !s_axi_arready && $past(s_axi_arready) && $past(s_axi_arvalid);
   endproperty
   a_r_cause: assert property (p_r_cause)
      else $error("read answered without address handshake");

   property p_r_done;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
   endproperty
   a_r_done: assert property (p_r_done)
      else $error("read response not retired");
endmodule

bind epou_top epou_monitor epou_monitor_inst (
   .aclk(aclk), .aresetn(aresetn), .sleep(sleep),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .bridge_out_o(bridge_out_o), .bridge_out_oe(bridge_out_oe),
   .unit_owns_pin(unit_owns_pin)
);
`default_nettype wire

/* File: logic/epou_map.svh */
// register offsets, field positions, reset values and timing counts
// assumes: included by the package and the top module of the pwm unit
`ifndef EPOU_MAP_SVH
`define EPOU_MAP_SVH

// ==========================================================================
// register byte offsets
`define EPOU_OFS_CONTROL 8'h00
`define EPOU_OFS_DUTY_HIGH 8'h04
`define EPOU_OFS_DUTY_ACTIVE 8'h08
`define EPOU_OFS_PERIOD_LIMIT 8'h0C
`define EPOU_OFS_PERIOD_COUNTER 8'h10
`define EPOU_OFS_TIMER_CONTROL 8'h14
`define EPOU_OFS_FLAGS 8'h18
`define EPOU_OFS_PIN_DIRECTION 8'h1C
`define EPOU_OFS_DEADBAND 8'h20
`define EPOU_OFS_STEERING 8'h24

// ==========================================================================
// control register fields
`define EPOU_CTL_MODE_HI 7
`define EPOU_CTL_MODE_LO 6
`define EPOU_CTL_DUTY_HI 5
`define EPOU_CTL_DUTY_LO 4
`define EPOU_CTL_PWM_HI 3
`define EPOU_CTL_PWM_LO 2
`define EPOU_CTL_POL_AC 1
`define EPOU_CTL_POL_BD 0
`define EPOU_PWM_SELECT 2'h3

// output modes
`define EPOU_MODE_SINGLE 2'h0
`define EPOU_MODE_FULL_FWD 2'h1
`define EPOU_MODE_HALF 2'h2
`define EPOU_MODE_FULL_REV 2'h3

// timer control fields
`define EPOU_TMR_RUN 2
`define EPOU_TMR_PS_HI 1
`define EPOU_TMR_PS_LO 0
`define EPOU_TMR_POST_HI 6
`define EPOU_TMR_POST_LO 3

// flag register fields
`define EPOU_FLG_PERIOD 0

// ==========================================================================
// reset values
`define EPOU_RST_CONTROL 8'h00
`define EPOU_RST_DUTY 8'h00
`define EPOU_RST_PERIOD_LIMIT 8'hFF
`define EPOU_RST_TIMER_CONTROL 8'h00
`define EPOU_RST_PIN_DIRECTION 4'hF
`define EPOU_RST_DEADBAND 7'h00
`define EPOU_RST_STEERING 4'h1

// ==========================================================================
// timing: oscillator clocks per instruction cycle, prescaler wrap counts
`define EPOU_OSC_PER_CYCLE 9'h004
`define EPOU_PS_WRAP_1 6'h03
`define EPOU_PS_WRAP_4 6'h0F
`define EPOU_PS_WRAP_16 6'h3F

// bus answers
`define EPOU_RESP_OKAY 2'h0
`define EPOU_RESP_SLVERR 2'h2

`endif

/* File: logic/epou_pkg.sv */
// types of the enhanced pwm output unit
// assumes: epou_map.svh on the include path
`include "epou_map.svh"

package epou_pkg;

   // whole state of the unit, registered in one place
   typedef struct packed {
      // bus slave
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] aw_addr;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      // software registers
      logic [7:0] control;
      logic [7:0] duty_high;
      logic [7:0] duty_active;
      logic [1:0] duty_latch;
      logic [7:0] period_limit;
      logic [7:0] period_counter;
      logic [7:0] timer_control;
      logic period_flag;
      logic [3:0] pin_direction;
      logic [6:0] deadband;
      logic [3:0] steering;
      // time base and waveform
      logic [5:0] prescale;
      logic pwm_raw;
      logic started;
      logic [8:0] dead_a;
      logic [8:0] dead_b;
      // pins
      logic [3:0] pin_out;
      logic [3:0] pin_oe;
      logic [3:0] pin_owned;
   } epou_state_t;

endpackage

/* File: logic/epou_top.sv */
// enhanced pwm output unit with an axi4-lite register slave
// assumes: one 20 MHz clock, synchronous active-low reset, pins resolved outside
//
// Summary of operation
// - period is (limit+1) x 4 x prescale clocks
// - rollover clears counter, sets output unless 0%
// - rollover copies duty setpoint into active buffer
// - postscaler does not affect the period
// - duty is ten bits, high8 plus control 5:4
// - new duty applies only after period match
// - active buffer read-only while pwm runs
// - duty double buffered with two-bit latch
// - time base is counter plus two low bits
// - time base equal to duty drives output low
// - pulse longer than period leaves outputs unchanged
// - full ten-bit resolution only at limit 255
// - prescaler divides by 1, 4 or 16
// - sleep freezes counter, state and pin levels
// - reset restores registers, pins become inputs
// - mode bits select single, half, full bridges
// - mode decides which outputs are used
// - output polarity selectable by control bits
// - output withheld until a new period begins
// - zero control register releases all pins
// - unused pins stay free for port functions
// - half bridge: complement with dead-band delay
// - full bridge: one held active, one modulated
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`include "epou_map.svh"
`timescale 1ns/10ps
`default_nettype none

module epou_top #(
   parameter int DUTY_W = 10,
   parameter int DEAD_W = 7
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sleep,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] bridge_out_o,
   output logic [3:0] bridge_out_oe,
   output logic [3:0] unit_owns_pin
);
   import epou_pkg::*;

   // =======================================================================
   // parameter checks
   if (DUTY_W != 10) begin : g_bad_duty
      $error("duty width must be 10");
   end
   if (DEAD_W != 7) begin : g_bad_dead
      $error("dead-band width must be 7");
   end

   epou_state_t st_q;
   epou_state_t st_d;

   // =======================================================================
   // next-state logic
   always_comb begin
      logic pwm_on;
      logic [1:0] mode;
      logic run;
      logic [5:0] ps_wrap;
      logic [1:0] low2;
      logic tick;
      logic rollover;
      logic [9:0] time_base;
      logic [8:0] dead_len;
      logic act_a;
      logic act_b;
      logic [3:0] act;
      logic [3:0] used;
      logic [3:0] pol;
      logic wr_go;
      logic [7:0] wa;
      logic [7:0] wd;
      logic bad_w;
      logic [7:0] ra;
      logic [31:0] rd;
      logic bad_r;
      pwm_on = 1'b0;
      mode = 2'h0;
      run = 1'b0;
      ps_wrap = 6'h00;
      low2 = 2'h0;
      tick = 1'b0;
      rollover = 1'b0;
      time_base = 10'h000;
      dead_len = 9'h000;
      act_a = 1'b0;
      act_b = 1'b0;
      act = 4'h0;
      used = 4'h0;
      pol = 4'h0;
      wr_go = 1'b0;
      wa = 8'h00;
      wd = 8'h00;
      bad_w = 1'b0;
      ra = 8'h00;
      rd = 32'h0000_0000;
      bad_r = 1'b0;
      st_d = st_q;

      // ====================================================================
      // axi4-lite write: address and data taken in either order
      if (s_axi_awvalid && st_q.awready) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
         st_d.awready = 1'b0;
      end
      if (s_axi_wvalid && st_q.wready) begin
         st_d.w_held = 1'b1;
         st_d.w_data = s_axi_wdata[7:0];
         st_d.w_lane0 = s_axi_wstrb[0];
         st_d.wready = 1'b0;
      end
      if (st_q.aw_held && st_q.w_held && !st_q.bvalid) begin
         wr_go = st_q.w_lane0;
         wa = st_q.aw_addr;
         wd = st_q.w_data;
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         bad_w = 1'b0;
         case (st_q.aw_addr)
            `EPOU_OFS_CONTROL, `EPOU_OFS_DUTY_HIGH, `EPOU_OFS_DUTY_ACTIVE,
            `EPOU_OFS_PERIOD_LIMIT, `EPOU_OFS_PERIOD_COUNTER,
            `EPOU_OFS_TIMER_CONTROL, `EPOU_OFS_FLAGS, `EPOU_OFS_PIN_DIRECTION,
            `EPOU_OFS_DEADBAND, `EPOU_OFS_STEERING: bad_w = 1'b0;
            default: bad_w = 1'b1;
         endcase
         st_d.bresp = bad_w ? `EPOU_RESP_SLVERR : `EPOU_RESP_OKAY;
         if (bad_w) begin
            wr_go = 1'b0;
         end
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
         st_d.awready = 1'b1;
         st_d.wready = 1'b1;
      end

      pwm_on = (st_q.control[`EPOU_CTL_PWM_HI:`EPOU_CTL_PWM_LO] == `EPOU_PWM_SELECT);
      if (wr_go) begin
         case (wa)
            `EPOU_OFS_CONTROL: st_d.control = wd;
            `EPOU_OFS_DUTY_HIGH: st_d.duty_high = wd;
            `EPOU_OFS_DUTY_ACTIVE: begin
               if (!pwm_on) begin
                  st_d.duty_active = wd;
               end
            end
            `EPOU_OFS_PERIOD_LIMIT: st_d.period_limit = wd;
            `EPOU_OFS_PERIOD_COUNTER: st_d.period_counter = wd;
            `EPOU_OFS_TIMER_CONTROL: st_d.timer_control = {1'b0, wd[6:0]};
            `EPOU_OFS_FLAGS: begin
               if (wd[`EPOU_FLG_PERIOD]) begin
                  st_d.period_flag = 1'b0;
               end
            end
            `EPOU_OFS_PIN_DIRECTION: st_d.pin_direction = wd[3:0];
            `EPOU_OFS_DEADBAND: st_d.deadband = wd[6:0];
            `EPOU_OFS_STEERING: st_d.steering = wd[3:0];
            default: st_d.period_flag = st_d.period_flag;
         endcase
      end

      // ====================================================================
      // axi4-lite read
      if (s_axi_arvalid && st_q.arready) begin
         ra = s_axi_araddr;
         bad_r = 1'b0;
         case (ra)
            `EPOU_OFS_CONTROL: rd = {24'h000000, st_q.control};
            `EPOU_OFS_DUTY_HIGH: rd = {24'h000000, st_q.duty_high};
            `EPOU_OFS_DUTY_ACTIVE: rd = {24'h000000, st_q.duty_active};
            `EPOU_OFS_PERIOD_LIMIT: rd = {24'h000000, st_q.period_limit};
            `EPOU_OFS_PERIOD_COUNTER: rd = {24'h000000, st_q.period_counter};
            `EPOU_OFS_TIMER_CONTROL: rd = {24'h000000, st_q.timer_control};
            `EPOU_OFS_FLAGS: rd = {31'h00000000, st_q.period_flag};
            `EPOU_OFS_PIN_DIRECTION: rd = {28'h0000000, st_q.pin_direction};
            `EPOU_OFS_DEADBAND: rd = {25'h0000000, st_q.deadband};
            `EPOU_OFS_STEERING: rd = {28'h0000000, st_q.steering};
            default: bad_r = 1'b1;
         endcase
         st_d.rdata = rd;
         st_d.rresp = bad_r ? `EPOU_RESP_SLVERR : `EPOU_RESP_OKAY;
         st_d.rvalid = 1'b1;
         st_d.arready = 1'b0;
      end
      if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid = 1'b0;
         st_d.arready = 1'b1;
      end

      // ====================================================================
      // time base
      mode = st_q.control[`EPOU_CTL_MODE_HI:`EPOU_CTL_MODE_LO];
      run = st_q.timer_control[`EPOU_TMR_RUN];
      case (st_q.timer_control[`EPOU_TMR_PS_HI:`EPOU_TMR_PS_LO])
         2'h0: ps_wrap = `EPOU_PS_WRAP_1;
         2'h1: ps_wrap = `EPOU_PS_WRAP_4;
         default: ps_wrap = `EPOU_PS_WRAP_16;
      endcase
      if (run && !sleep) begin
         tick = (st_q.prescale == ps_wrap);
         st_d.prescale = tick ? 6'h00 : st_q.prescale + 6'h01;
      end
      rollover = tick && (st_q.period_counter == st_q.period_limit);
      if (tick) begin
         st_d.period_counter = rollover ? 8'h00 : st_q.period_counter + 8'h01;
      end
      if (rollover) begin
         st_d.period_flag = 1'b1;
         st_d.duty_active = st_q.duty_high;
         st_d.duty_latch = st_q.control[`EPOU_CTL_DUTY_HI:`EPOU_CTL_DUTY_LO];
      end
      // clock quadrature or prescaler bits
      // time base after this edge, so the clear edge lines up with the set edge
      case (st_q.timer_control[`EPOU_TMR_PS_HI:`EPOU_TMR_PS_LO])
         2'h0: low2 = st_d.prescale[1:0];
         2'h1: low2 = st_d.prescale[3:2];
         default: low2 = st_d.prescale[5:4];
      endcase
      time_base = {st_d.period_counter, low2};

      // ====================================================================
      // modulated waveform
      if (!sleep) begin
         if (!pwm_on) begin
            st_d.pwm_raw = 1'b0;
            st_d.started = 1'b0;
         end else if (rollover) begin
            st_d.pwm_raw = ({st_q.duty_high, st_q.control[5:4]} != 10'h000);
            // waveform starts at a period edge
            st_d.started = 1'b1;
         end else if (run && time_base == {st_q.duty_active, st_q.duty_latch}) begin
            st_d.pwm_raw = 1'b0;
         end
      end

      // ====================================================================
      // dead band and steering
      dead_len = {2'h0, st_q.deadband} * `EPOU_OSC_PER_CYCLE;
      if (!sleep) begin
         if (st_q.pwm_raw && st_q.started) begin
            st_d.dead_a = (st_q.dead_a < dead_len) ? st_q.dead_a + 9'h001 : st_q.dead_a;
         end else begin
            st_d.dead_a = 9'h000;
         end
         if (!st_q.pwm_raw && st_q.started) begin
            st_d.dead_b = (st_q.dead_b < dead_len) ? st_q.dead_b + 9'h001 : st_q.dead_b;
         end else begin
            st_d.dead_b = 9'h000;
         end
      end
      act_a = st_q.pwm_raw && (st_q.dead_a >= dead_len);
      act_b = !st_q.pwm_raw && st_q.started && (st_q.dead_b >= dead_len);
      case (mode)
         `EPOU_MODE_SINGLE: begin
            act = {4{st_q.pwm_raw}};
            used = st_q.steering;
         end
         `EPOU_MODE_HALF: begin
            act = {2'b00, act_b, act_a};
            used = 4'h3;
         end
         `EPOU_MODE_FULL_FWD: begin
            act = {st_q.pwm_raw, 2'b00, 1'b1};
            used = 4'hF;
         end
         `EPOU_MODE_FULL_REV: begin
            act = {1'b0, 1'b1, st_q.pwm_raw, 1'b0};
            used = 4'hF;
         end
         default: begin
            act = 4'h0;
            used = 4'h0;
         end
      endcase
      if (!st_q.started) begin
         act = 4'h0;
      end
      pol = {st_q.control[`EPOU_CTL_POL_BD], st_q.control[`EPOU_CTL_POL_AC],
             st_q.control[`EPOU_CTL_POL_BD], st_q.control[`EPOU_CTL_POL_AC]};
      if (!sleep) begin
         for (int i = 0; i < 4; i++) begin
            // no pwm mode owns no pin
            st_d.pin_owned[i] = pwm_on && used[i];
            st_d.pin_out[i] = st_d.pin_owned[i] && (act[i] ^ pol[i]);
            st_d.pin_oe[i] = st_d.pin_owned[i] && !st_q.pin_direction[i];
         end
      end
   end

   // =======================================================================
   // state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= '0;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
         st_q.control <= `EPOU_RST_CONTROL;
         st_q.duty_high <= `EPOU_RST_DUTY;
         st_q.duty_active <= `EPOU_RST_DUTY;
         st_q.period_limit <= `EPOU_RST_PERIOD_LIMIT;
         st_q.timer_control <= `EPOU_RST_TIMER_CONTROL;
         st_q.pin_direction <= `EPOU_RST_PIN_DIRECTION;
         st_q.deadband <= `EPOU_RST_DEADBAND;
         st_q.steering <= `EPOU_RST_STEERING;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready = st_q.wready;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign bridge_out_o = st_q.pin_out;
   assign bridge_out_oe = st_q.pin_oe;
   assign unit_owns_pin = st_q.pin_owned;

endmodule

`default_nettype wire
